// [verilog/wau_pkg.sv]
// Package for the word add overflow unit: opcode fields, widths, types.
// Assumes a 32-bit instruction word and a 32- or 64-bit register file.
package wau_pkg;
    // ************************************************************
    // Instruction field layout
    // ************************************************************
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RS_HI = 25;
    localparam int RS_LO = 21;
    localparam int RT_HI = 20;
    localparam int RT_LO = 16;
    localparam int RD_HI = 15;
    localparam int RD_LO = 11;
    localparam int SH_HI = 10;
    localparam int SH_LO = 6;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;
    localparam int IMM_HI = 15;
    localparam int IMM_LO = 0;
    localparam int WORD_MSB = 31;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [5:0] OPC_ZERO_GROUP = 6'h00;
    localparam logic [5:0] OPC_ADD_IMM_TRAP = 6'h08;
    localparam logic [5:0] OPC_ADD_IMM_MOD = 6'h09;
    localparam logic [5:0] FN_ADD_TRAP = 6'h20;
    localparam logic [4:0] SHAMT_ZERO = 5'h00;

    // Operation selected by the decoder
    typedef enum logic [1:0] {
        WAU_OP_NONE = 2'h0,
        WAU_OP_ADD_REG = 2'h1,
        WAU_OP_ADD_IMM_TRAP = 2'h3,
        WAU_OP_ADD_IMM_MOD = 2'h2
    } wau_op_t;

    // Issue bundle from the pipeline
    typedef struct packed {
        logic valid;
        logic [31:0] instr;
    } wau_issue_t;

    // Decoded fields
    typedef struct packed {
        wau_op_t op;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [4:0] dest;
        logic [15:0] imm;
    } wau_dec_t;
endpackage : wau_pkg

// [verilog/wau_decode.sv]
// Instruction decoder for the word add overflow unit.
// Assumes a valid 32-bit instruction word arriving from the pipeline.
`timescale 1ns/1ps
`default_nettype none
module wau_decode (
    // Instruction in
    input wire wau_pkg::wau_issue_t issue,
    // Decoded fields out
    output var wau_pkg::wau_dec_t dec
);
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] sh;

    // Field extraction
    assign opc = issue.instr[wau_pkg::OPC_HI:wau_pkg::OPC_LO];
    assign fn = issue.instr[wau_pkg::FN_HI:wau_pkg::FN_LO];
    assign sh = issue.instr[wau_pkg::SH_HI:wau_pkg::SH_LO];

    // Opcode match; unknown words fall to no operation
    always_comb begin
        dec.src_a = issue.instr[wau_pkg::RS_HI:wau_pkg::RS_LO];
        dec.src_b = issue.instr[wau_pkg::RT_HI:wau_pkg::RT_LO];
        dec.imm = issue.instr[wau_pkg::IMM_HI:wau_pkg::IMM_LO];
        dec.dest = issue.instr[wau_pkg::RD_HI:wau_pkg::RD_LO];
        dec.op = wau_pkg::WAU_OP_NONE;
        if (issue.valid) begin
            if (opc == wau_pkg::OPC_ZERO_GROUP && fn == wau_pkg::FN_ADD_TRAP
                && sh == wau_pkg::SHAMT_ZERO) begin
                dec.op = wau_pkg::WAU_OP_ADD_REG;
            end else if (opc == wau_pkg::OPC_ADD_IMM_TRAP) begin
                dec.op = wau_pkg::WAU_OP_ADD_IMM_TRAP;
                dec.dest = dec.src_b;
            end else if (opc == wau_pkg::OPC_ADD_IMM_MOD) begin
                dec.op = wau_pkg::WAU_OP_ADD_IMM_MOD;
                dec.dest = dec.src_b;
            end
        end
    end
endmodule : wau_decode
`default_nettype wire

// [verilog/wau_unit.sv]
// Word add execution stage: decode, 32-bit add, overflow trap, registered write.
// Assumes operands are read from the register file in the issue cycle.
// Result registers keep their last write; only the flags are pulses.
// XLEN may be 32 or 64; wider sources only ever contribute their low word.
`timescale 1ns/1ps
`default_nettype none
module wau_unit #(
    parameter int XLEN = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Issue from pipeline
    input wire wau_pkg::wau_issue_t issue,
    input wire logic [XLEN-1:0] src_a_val,
    input wire logic [XLEN-1:0] src_b_val,
    // Register specifiers to the file
    output logic [4:0] src_a_sel,
    output logic [4:0] src_b_sel,
    // Result
    output logic wr_en_q,
    output logic [4:0] wr_addr_q,
    output logic [XLEN-1:0] wr_data_q,
    output logic ovf_exc_q,
    output logic done_q
);
    // ************************************************************
    // Decode
    // ************************************************************
    wau_pkg::wau_dec_t dec;

    wau_decode u_dec (
        .issue(issue),
        .dec(dec)
    );

    assign src_a_sel = dec.src_a;
    assign src_b_sel = dec.src_b;

    // ************************************************************
    // Adder and overflow
    // ************************************************************
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [31:0] sum;
    logic ovf;
    logic trap_op;
    logic take_exc;
    logic do_write;
    logic is_op;

    // Sign copies needed to stretch the immediate to a word
    localparam int IMM_EXT = wau_pkg::WORD_MSB - wau_pkg::IMM_HI;

    // Only low words feed the adder; unextended sources are undefined anyway
    assign opnd_a = src_a_val[wau_pkg::WORD_MSB:0];
    // Immediate forms use the sign-extended 16-bit field
    assign opnd_b = (dec.op == wau_pkg::WAU_OP_ADD_REG) ? src_b_val[wau_pkg::WORD_MSB:0]
                  : {{IMM_EXT{dec.imm[wau_pkg::IMM_HI]}}, dec.imm};
    assign sum = opnd_a + opnd_b;
    // Same-sign addends with a sign flip in the sum
    assign ovf = (opnd_a[wau_pkg::WORD_MSB] == opnd_b[wau_pkg::WORD_MSB])
              && (sum[wau_pkg::WORD_MSB] != opnd_a[wau_pkg::WORD_MSB]);
    assign trap_op = (dec.op == wau_pkg::WAU_OP_ADD_REG)
                  || (dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP);
    assign take_exc = trap_op && ovf;
    assign is_op = (dec.op != wau_pkg::WAU_OP_NONE);
    // Modulo form never traps, so it always writes
    assign do_write = is_op && !take_exc;

    // ************************************************************
    // Result registers
    // ************************************************************
    // Write port; the write is dropped on a trap so the target stays intact
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_en_q <= 1'b0;
        end else begin
            wr_en_q <= do_write;
        end
    end

    // Data path; held when no write so stale data is harmless
    // The signed cast repeats bit 31 upward and still elaborates when XLEN is 32
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_addr_q <= 5'h00;
            wr_data_q <= '0;
        end else if (do_write) begin
            wr_addr_q <= dec.dest;
            wr_data_q <= XLEN'($signed(sum));
        end
    end

    // Exception and completion flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_exc_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ovf_exc_q <= take_exc;
            done_q <= is_op;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_no_write_on_exc;
        @(posedge clk) disable iff (sys_rst) ovf_exc_q |-> !wr_en_q;
    endproperty
    a_no_write_on_exc: assert property (p_no_write_on_exc) else $error("write with trap");

    property p_reg_add_trap;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_REG && src_a_val[31] == src_b_val[31]
         && (src_a_val[31:0] + src_b_val[31:0]) >> 31 != {31'h0, src_a_val[31]})
        |=> ovf_exc_q && !wr_en_q;
    endproperty
    a_reg_add_trap: assert property (p_reg_add_trap) else $error("add overflow missed");

    property p_sext;
        @(posedge clk) disable iff (sys_rst)
        wr_en_q |-> (wr_data_q[XLEN-1:31] == '0) || (&wr_data_q[XLEN-1:31]);
    endproperty
    a_sext: assert property (p_sext) else $error("result not sign-extended");

    property p_mod_never_traps;
        @(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_IMM_MOD |=> wr_en_q && !ovf_exc_q;
    endproperty
    a_mod_never_traps: assert property (p_mod_never_traps) else $error("modulo add trapped");

    property p_imm_data;
        @(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_IMM_MOD |=>
        wr_data_q[31:0] == $past(src_a_val[31:0]) + {{16{$past(dec.imm[15])}}, $past(dec.imm)};
    endproperty
    a_imm_data: assert property (p_imm_data) else $error("immediate sum wrong");

    property p_imm_dest;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP && !ovf) |=>
        wr_en_q && wr_addr_q == $past(issue.instr[20:16]);
    endproperty
    a_imm_dest: assert property (p_imm_dest) else $error("wrong immediate target");

    property p_decode_reg;
        @(posedge clk) disable iff (sys_rst)
        (issue.valid && issue.instr[31:26] == 6'h00 && issue.instr[5:0] == 6'h20
         && issue.instr[10:6] == 5'h00) |-> dec.op == wau_pkg::WAU_OP_ADD_REG;
    endproperty
    a_decode_reg: assert property (p_decode_reg) else $error("register add not decoded");

    property p_decode_mod;
        @(posedge clk) disable iff (sys_rst)
        (issue.valid && issue.instr[31:26] == 6'h09) |-> dec.op == wau_pkg::WAU_OP_ADD_IMM_MOD;
    endproperty
    a_decode_mod: assert property (p_decode_mod) else $error("modulo add not decoded");

    property p_ovf_rule;
        @(posedge clk) disable iff (sys_rst)
        (trap_op && opnd_a[31] != opnd_b[31]) |=> !ovf_exc_q;
    endproperty
    a_ovf_rule: assert property (p_ovf_rule) else $error("mixed-sign add trapped");

    // ************************************************************
    // Checker reference sums
    // ************************************************************
    // Built from the raw operands, not the adder's inputs, so that a slip in
    // the operand mux or in the overflow term cannot hide behind itself
    localparam int WIDE_MSB = wau_pkg::WORD_MSB + 1;
    logic [WIDE_MSB:0] chk_wide_reg;
    logic [WIDE_MSB:0] chk_wide_imm;
    logic chk_ovf_reg;
    logic chk_ovf_imm;
    logic chk_trap_due;

    assign chk_wide_reg = {src_a_val[wau_pkg::WORD_MSB], src_a_val[wau_pkg::WORD_MSB:0]}
                        + {src_b_val[wau_pkg::WORD_MSB], src_b_val[wau_pkg::WORD_MSB:0]};
    assign chk_wide_imm = {src_a_val[wau_pkg::WORD_MSB], src_a_val[wau_pkg::WORD_MSB:0]}
                        + {{(IMM_EXT + 1){dec.imm[wau_pkg::IMM_HI]}}, dec.imm};
    // A word-plus-one signed sum overflows a word when its top two bits differ
    assign chk_ovf_reg = chk_wide_reg[WIDE_MSB] != chk_wide_reg[wau_pkg::WORD_MSB];
    assign chk_ovf_imm = chk_wide_imm[WIDE_MSB] != chk_wide_imm[wau_pkg::WORD_MSB];
    // Only the two trapping forms may raise the exception
    assign chk_trap_due = (dec.op == wau_pkg::WAU_OP_ADD_REG && chk_ovf_reg)
                       || (dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP && chk_ovf_imm);

    // ************************************************************
    // Assertions against the reference sums
    // ************************************************************
    // Register add: clean sums land at rd, overflowing ones trap
    property p_reg_add_data;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_REG && !chk_ovf_reg) |=> wr_en_q && !ovf_exc_q
        && wr_data_q[wau_pkg::WORD_MSB:0] == $past(chk_wide_reg[wau_pkg::WORD_MSB:0])
        && wr_addr_q == $past(issue.instr[wau_pkg::RD_HI:wau_pkg::RD_LO]);
    endproperty
    a_reg_add_data: assert property (p_reg_add_data) else $error("reg sum wrong");

    property p_reg_add_ovf;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_REG && chk_ovf_reg) |=> ovf_exc_q && !wr_en_q && done_q;
    endproperty
    a_reg_add_ovf: assert property (p_reg_add_ovf) else $error("reg trap missed");

    // Trapping immediate form: same split, the target is rt
    property p_imm_trap_ovf;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP && chk_ovf_imm) |=> ovf_exc_q && !wr_en_q;
    endproperty
    a_imm_trap_ovf: assert property (p_imm_trap_ovf) else $error("imm trap missed");

    property p_imm_trap_data;
        @(posedge clk) disable iff (sys_rst)
        (dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP && !chk_ovf_imm) |=> wr_en_q && !ovf_exc_q
        && wr_data_q[wau_pkg::WORD_MSB:0] == $past(chk_wide_imm[wau_pkg::WORD_MSB:0]);
    endproperty
    a_imm_trap_data: assert property (p_imm_trap_data) else $error("imm sum wrong");

    // Modulo form keeps only the low word of the same sum and writes rt
    property p_mod_data;
        @(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_IMM_MOD |=>
        wr_data_q[wau_pkg::WORD_MSB:0] == $past(chk_wide_imm[wau_pkg::WORD_MSB:0])
        && wr_addr_q == $past(issue.instr[wau_pkg::RT_HI:wau_pkg::RT_LO]);
    endproperty
    a_mod_data: assert property (p_mod_data) else $error("modulo result wrong");

    // Decode of the trapping immediate and refusal of a nonzero shift field
    property p_decode_imm_trap;
        @(posedge clk) disable iff (sys_rst)
        (issue.valid && issue.instr[wau_pkg::OPC_HI:wau_pkg::OPC_LO] == 6'h08)
        |-> dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP;
    endproperty
    a_decode_imm_trap: assert property (p_decode_imm_trap)
        else $error("imm add not decoded");

    property p_refuse_shift;
        @(posedge clk) disable iff (sys_rst)
        (issue.valid && issue.instr[wau_pkg::OPC_HI:wau_pkg::OPC_LO] == 6'h00
         && issue.instr[wau_pkg::SH_HI:wau_pkg::SH_LO] != 5'h00)
        |-> dec.op == wau_pkg::WAU_OP_NONE;
    endproperty
    a_refuse_shift: assert property (p_refuse_shift) else $error("bad shift decoded");

    // Nothing decoded means nothing reported the next cycle
    property p_idle_quiet;
        @(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_NONE |=> !wr_en_q && !ovf_exc_q && !done_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("flag without add");

    // A trap leaves the write port exactly as the last good write left it
    property p_hold_on_trap;
        @(posedge clk) disable iff (sys_rst)
        ovf_exc_q |-> $stable(wr_data_q) && $stable(wr_addr_q);
    endproperty
    a_hold_on_trap: assert property (p_hold_on_trap) else $error("trap moved data");

    // Every trap traces back to a trapping add whose reference sum overflowed
    property p_trap_cause;
        @(posedge clk) disable iff (sys_rst)
        ovf_exc_q |-> $past(chk_trap_due);
    endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("spurious trap");

    // Completion is reported exactly when a write or a trap is
    property p_done_match;
        @(posedge clk) disable iff (sys_rst)
        done_q == (wr_en_q || ovf_exc_q);
    endproperty
    a_done_match: assert property (p_done_match) else $error("done mismatch");

    // Reset leaves no stray write or trap behind; not disabled by reset itself
    property p_reset_quiet;
        @(posedge clk) sys_rst |=> !wr_en_q && !ovf_exc_q && !done_q;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("flag after reset");

    // Scenarios worth seeing at least once

    c_trap: cover property (@(posedge clk) disable iff (sys_rst) ovf_exc_q);
    c_reg_write: cover property (@(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_REG ##1 wr_en_q);
    c_mod_wrap: cover property (@(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_IMM_MOD && ovf);
    c_imm_trap: cover property (@(posedge clk) disable iff (sys_rst)
        dec.op == wau_pkg::WAU_OP_ADD_IMM_TRAP ##1 ovf_exc_q);
    c_back_to_back: cover property (@(posedge clk) disable iff (sys_rst) wr_en_q ##1 wr_en_q);
endmodule : wau_unit
`default_nettype wire

// [bench/wau_regfile_model.sv]
// Register file model standing at the far side of the word add unit.
// Assumes reads are combinational and writes land on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module wau_regfile_model (
    // Clock
    input wire logic clk,
    // Read side
    input wire logic [4:0] sel_a,
    input wire logic [4:0] sel_b,
    output logic [63:0] val_a,
    output logic [63:0] val_b,
    // Write side
    input wire logic wr_en,
    input wire logic ovf,
    input wire logic [4:0] wr_addr,
    input wire logic [63:0] wr_data
);
    logic [63:0] regs [32];
    // Reads settle within the issue cycle
    assign val_a = regs[sel_a];
    assign val_b = regs[sel_b];
    // A flagged overflow never reaches the file, even if the enable slips
    always @(posedge clk) begin
        if (wr_en && !ovf) begin
            regs[wr_addr] <= wr_data;
        end
    end
endmodule : wau_regfile_model
`default_nettype wire

// [bench/word_add_overflow_unit_tb_top.sv]
// Self-checking bench for the word add unit with a 64-bit register file.
// Assumes one-cycle answers and held result registers between writes.
`timescale 1ns/1ps
`default_nettype none
module word_add_overflow_unit_tb_top;
    logic clk;
    logic sys_rst;
    wau_pkg::wau_issue_t issue;
    logic [63:0] a_val, b_val, wr_data_q;
    logic [4:0] a_sel, b_sel, wr_addr_q;
    logic wr_en_q, ovf_exc_q, done_q;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [63:0] held_data = 64'h0;
    logic [4:0] held_addr = 5'h00;

    wau_unit #(.XLEN(64)) dut (.clk(clk), .sys_rst(sys_rst), .issue(issue),
        .src_a_val(a_val), .src_b_val(b_val), .src_a_sel(a_sel), .src_b_sel(b_sel),
        .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
        .ovf_exc_q(ovf_exc_q), .done_q(done_q));
    wau_regfile_model rf (.clk(clk), .sel_a(a_sel), .sel_b(b_sel), .val_a(a_val),
        .val_b(b_val), .wr_en(wr_en_q), .ovf(ovf_exc_q), .wr_addr(wr_addr_q),
        .wr_data(wr_data_q));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    function automatic logic [31:0] rtype(input logic [4:0] s, t, d, sh, input logic [5:0] fn);
        return {wau_pkg::OPC_ZERO_GROUP, s, t, d, sh, fn};
    endfunction : rtype

    function automatic logic [31:0] itype(input logic [5:0] op, input logic [4:0] s, t,
        input logic [15:0] imm);
        return {op, s, t, imm};
    endfunction : itype

    // One instruction for one cycle; the answer is judged one cycle later
    task automatic run(input logic [31:0] ins, input logic wr, ovf, input logic [4:0] ad,
        input logic [63:0] data);
        @(posedge clk);
        #1 issue = {1'b1, ins};
        @(posedge clk);
        #1 issue.valid = 1'b0;
        if (wr) begin
            held_data = data;
            held_addr = ad;
        end
        chk_bit("wr_en_q", wr, wr_en_q);
        chk_bit("ovf_exc_q", ovf, ovf_exc_q);
        chk_bit("done_q", wr | ovf, done_q);
        chk_word("wr_data_q", held_data, wr_data_q);
        chk_word("wr_addr_q", {59'h0, held_addr}, {59'h0, wr_addr_q});
    endtask : run

    task automatic t_reg_add;
        rf.regs[1] = 64'h5;
        rf.regs[2] = 64'hFFFFFFFFFFFFFFFD;
        run(rtype(5'h01, 5'h02, 5'h03, 5'h00, wau_pkg::FN_ADD_TRAP),
            1'b1, 1'b0, 5'h03, 64'h2);
        rf.regs[1] = 64'h7FFFFFFF;
        rf.regs[2] = 64'h1;
        run(rtype(5'h01, 5'h02, 5'h04, 5'h00, wau_pkg::FN_ADD_TRAP),
            1'b0, 1'b1, 5'h00, 64'h0);
        rf.regs[1] = 64'hFFFFFFFF80000000;
        rf.regs[2] = 64'hFFFFFFFFFFFFFFFF;
        run(rtype(5'h01, 5'h02, 5'h04, 5'h00, wau_pkg::FN_ADD_TRAP),
            1'b0, 1'b1, 5'h00, 64'h0);
        rf.regs[2] = 64'h7FFFFFFF;
        run(rtype(5'h01, 5'h02, 5'h05, 5'h00, wau_pkg::FN_ADD_TRAP),
            1'b1, 1'b0, 5'h05, '1);
        $display("register add test finished");
    endtask : t_reg_add

    task automatic t_imm;
        rf.regs[4] = 64'hA;
        run(itype(wau_pkg::OPC_ADD_IMM_TRAP, 5'h04, 5'h06, 16'hFFFF),
            1'b1, 1'b0, 5'h06, 64'h9);
        rf.regs[4] = 64'hFFFFFFFF80000000;
        run(itype(wau_pkg::OPC_ADD_IMM_TRAP, 5'h04, 5'h07, 16'h8000),
            1'b0, 1'b1, 5'h00, 64'h0);
        run(itype(wau_pkg::OPC_ADD_IMM_MOD, 5'h04, 5'h07, 16'h8000),
            1'b1, 1'b0, 5'h07, 64'h7FFF8000);
        rf.regs[4] = 64'h7FFFFFFF;
        run(itype(wau_pkg::OPC_ADD_IMM_TRAP, 5'h04, 5'h08, 16'h7FFF),
            1'b0, 1'b1, 5'h00, 64'h0);
        run(itype(wau_pkg::OPC_ADD_IMM_MOD, 5'h04, 5'h08, 16'h0001),
            1'b1, 1'b0, 5'h08, 64'hFFFFFFFF80000000);
        $display("immediate add test finished");
    endtask : t_imm

    task automatic t_refused;
        run(rtype(5'h01, 5'h02, 5'h0A, 5'h01, wau_pkg::FN_ADD_TRAP),
            1'b0, 1'b0, 5'h00, 64'h0);
        run(rtype(5'h01, 5'h02, 5'h0A, 5'h00, 6'h21), 1'b0, 1'b0, 5'h00, 64'h0);
        run(itype(6'h0C, 5'h04, 5'h0A, 16'h0001), 1'b0, 1'b0, 5'h00, 64'h0);
        $display("refused word test finished");
    endtask : t_refused

    // Two adds on consecutive edges; neither may swallow the other
    task automatic t_back_to_back;
        rf.regs[11] = 64'h10;
        rf.regs[12] = 64'h20;
        @(posedge clk);
        #1 issue = {1'b1, itype(wau_pkg::OPC_ADD_IMM_MOD, 5'h0B, 5'h0D, 16'h0001)};
        @(posedge clk);
        #1 issue = {1'b1, rtype(5'h0B, 5'h0C, 5'h0E, 5'h00, wau_pkg::FN_ADD_TRAP)};
        chk_word("wr_data_q", 64'h11, wr_data_q);
        chk_word("wr_addr_q", 64'h0D, {59'h0, wr_addr_q});
        @(posedge clk);
        #1 issue.valid = 1'b0;
        chk_word("wr_data_q", 64'h30, wr_data_q);
        chk_word("wr_addr_q", 64'h0E, {59'h0, wr_addr_q});
        chk_bit("wr_en_q", 1'b1, wr_en_q);
        $display("back to back test finished");
    endtask : t_back_to_back

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        sys_rst = 1'b1;
        issue = '0;
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk_bit("wr_en_q", 1'b0, wr_en_q);
        chk_word("wr_data_q", 64'h0, wr_data_q);
        t_reg_add;
        t_imm;
        t_refused;
        t_back_to_back;
        report_and_stop;
    end
endmodule : word_add_overflow_unit_tb_top
`default_nettype wire
